// ===== logic/gdc_controller.v
// Host-side controller driving the isolated gate driver pins
`timescale 1ns/1ps
`include "gdc_defines.vh"
module gdc_controller #(
  parameter MUTE_CYCLES = `GDC_MUTE_CYCLES,
  parameter CLEAR_CYCLES = `GDC_CLEAR_CYCLES
) (
  sys_clk,
  rst,
  pwmCmd,
  useInverting,
  autoReset,
  enableReq,
  clearReq,
  pwmNonInv,
  pwmInv,
  enablePin,
  faultFlagPin,
  readyPin,
  driverEnabled,
  faultActive,
  supplyGood,
  clearBusy
);
  input wire sys_clk;
  input wire rst;
  input wire pwmCmd;
  input wire useInverting;
  input wire autoReset;
  input wire enableReq;
  input wire clearReq;
  output reg pwmNonInv;
  output reg pwmInv;
  output reg enablePin;
  input wire faultFlagPin;
  input wire readyPin;
  output reg driverEnabled;
  output reg faultActive;
  output reg supplyGood;
  output wire clearBusy;

  localparam [2:0] ST_IDLE = `GDC_ST_IDLE;
  localparam [2:0] ST_RUN = `GDC_ST_RUN;
  localparam [2:0] ST_MUTE = `GDC_ST_MUTE;
  localparam [2:0] ST_CLEAR = `GDC_ST_CLEAR;
  localparam [2:0] ST_RELEASE = `GDC_ST_RELEASE;
  localparam [`GDC_CNT_W-1:0] MUTE_MAX = MUTE_CYCLES;
  localparam [`GDC_CNT_W-1:0] CLEAR_MAX = CLEAR_CYCLES;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [`GDC_CNT_W-1:0] count;
  reg [`GDC_CNT_W-1:0] next_count;
  wire faultLevel;
  wire faultFell;
  wire readyLevel;

  // Open-drain flags idle high through pull-ups; fault flag low means fault, ready high means supply good
  gdc_pin_sync faultSync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pinIn(faultFlagPin),
    .level(faultLevel),
    .fell(faultFell)
  );
  gdc_pin_sync readySync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pinIn(readyPin),
    .level(readyLevel),
    .fell()
  );

  assign clearBusy = (state == ST_MUTE) || (state == ST_CLEAR) || (state == ST_RELEASE);

  always @* begin
    next_state = state;
    next_count = count;
    case (state)
      ST_IDLE: begin
        if (enableReq) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (faultFell) begin
          next_state = ST_MUTE;
          next_count = {`GDC_CNT_W{1'H0}};
        end else if (!enableReq) begin
          next_state = ST_IDLE;
        end
      end
      ST_MUTE: begin
        // Low time spent inside the mute window does not count
        if (count >= MUTE_MAX - 1'H1) begin
          next_state = ST_CLEAR;
          next_count = {`GDC_CNT_W{1'H0}};
        end else begin
          next_count = count + 1'H1;
        end
      end
      ST_CLEAR: begin
        if (count >= CLEAR_MAX - 1'H1) begin
          next_state = ST_RELEASE;
        end else begin
          next_count = count + 1'H1;
        end
      end
      ST_RELEASE: begin
        // Fault releases on the rising edge; wait until it is seen
        if (faultLevel) begin
          next_state = enableReq ? ST_RUN : ST_IDLE;
        end else if (clearReq) begin
          next_state = ST_MUTE;
          next_count = {`GDC_CNT_W{1'H0}};
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_count = {`GDC_CNT_W{1'H0}};
      end
    endcase
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      state <= ST_IDLE;
      count <= {`GDC_CNT_W{1'H0}};
      pwmNonInv <= 1'H0;
      pwmInv <= 1'H0;
      enablePin <= 1'H0;
      driverEnabled <= 1'H0;
      faultActive <= 1'H0;
      supplyGood <= 1'H0;
    end else begin
      state <= next_state;
      count <= next_count;
      // Inputs always driven to a defined level, never floating
      if (useInverting) begin
        pwmNonInv <= 1'H1;
        pwmInv <= ~pwmCmd;
      end else begin
        pwmNonInv <= pwmCmd;
        pwmInv <= 1'H0;
      end
      if (next_state == ST_MUTE || next_state == ST_CLEAR) begin
        enablePin <= 1'H0;
      end else if (next_state == ST_RUN && autoReset) begin
        // Per-cycle reset follows the command; off-time must exceed the filter
        // Inverting input carries ~pwmCmd, so its inversion is pwmCmd again
        enablePin <= pwmCmd;
      end else begin
        enablePin <= (next_state == ST_RUN) || (next_state == ST_RELEASE);
      end
      driverEnabled <= (next_state == ST_RUN);
      faultActive <= ~faultLevel;
      supplyGood <= readyLevel;
    end
  end
endmodule

// ===== logic/gdc_defines.vh
// Timing, counter-width and state-encoding constants for the gate driver controller
`ifndef GDC_DEFINES_VH
`define GDC_DEFINES_VH
`define GDC_CLK_PERIOD_NS 8
`define GDC_FAULT_MUTE_TIME_NS 40000
`define GDC_CLEAR_FILTER_TIME_NS 1000
`define GDC_MARGIN_NS 200
`define GDC_MUTE_CYCLES ((`GDC_FAULT_MUTE_TIME_NS + `GDC_CLK_PERIOD_NS - 1) / `GDC_CLK_PERIOD_NS)
`define GDC_CLEAR_CYCLES ((`GDC_CLEAR_FILTER_TIME_NS + `GDC_MARGIN_NS + `GDC_CLK_PERIOD_NS - 1) / `GDC_CLK_PERIOD_NS)
`define GDC_CNT_W 16
`define GDC_ST_IDLE 3'H0
`define GDC_ST_RUN 3'H1
`define GDC_ST_MUTE 3'H2
`define GDC_ST_CLEAR 3'H3
`define GDC_ST_RELEASE 3'H4
`endif

// ===== logic/gdc_pin_sync.v
// Three-flop pin synchroniser with agreement-based change detection
`timescale 1ns/1ps
module gdc_pin_sync (
  sys_clk,
  rst,
  pinIn,
  level,
  fell
);
  input wire sys_clk;
  input wire rst;
  input wire pinIn;
  output reg level;
  output reg fell;
  reg s1;
  reg s2;
  reg s3;
  always @(posedge sys_clk) begin
    if (rst) begin
      s1 <= 1'H1;
      s2 <= 1'H1;
      s3 <= 1'H1;
      level <= 1'H1;
      fell <= 1'H0;
    end else begin
      s1 <= pinIn;
      s2 <= s1;
      s3 <= s2;
      fell <= 1'H0;
      // A change counts once the second and third stages agree
      if (s2 == s3 && s3 != level) begin
        level <= s3;
        fell <= ~s3;
      end
    end
  end
endmodule

// ===== test/gdc_driver_model.sv
// Behavioural model of the isolated gate driver seen from the host pins
`timescale 1ns/1ps
module gdc_driver_model #(
  parameter MUTE = 10,
  parameter FIL = 4
) (
  input wire sys_clk,
  input wire nonInv,
  input wire inv,
  input wire enPin,
  input wire ocTrip,
  input wire supplyLow,
  output wire faultFlagPin,
  output wire readyPin,
  output wire gate
);
  logic fault = 1'b0;
  int age = 0;
  int lowCnt = 0;
  assign gate = enPin && nonInv && !inv && !fault && !supplyLow;
  // Pull-up resolves a released flag to high
  assign faultFlagPin = !fault;
  assign readyPin = !supplyLow;
  always @(posedge sys_clk) begin
    age <= fault ? age + 1 : 0;
    lowCnt <= (enPin || age < MUTE) ? 0 : lowCnt + 1;
    if (ocTrip && gate) begin
      fault <= 1'b1;
    end else if (enPin && lowCnt >= FIL) begin
      fault <= 1'b0;
    end
  end
endmodule

// ===== test/gdc_controller_checker.sv
// Port checker for the gate driver controller
`timescale 1ns/1ps
module gdc_controller_checker (
  input wire sys_clk,
  input wire rst,
  input wire useInverting,
  input wire autoReset,
  input wire pwmNonInv,
  input wire pwmInv,
  input wire enablePin,
  input wire driverEnabled,
  input wire faultActive,
  input wire clearBusy
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_inv_held_low: assert property (!useInverting && $past(!useInverting) |-> !pwmInv)
    else $error("inverting input not low");
  a_idle_enable_low: assert property (!driverEnabled && !clearBusy && !$past(clearBusy) |-> !enablePin)
    else $error("enable pin high while idle");
  a_auto_noninv: assert property (driverEnabled && autoReset && !useInverting |-> enablePin == pwmNonInv)
    else $error("enable pin not following command");
  a_auto_inv: assert property (driverEnabled && autoReset && useInverting |-> enablePin != pwmInv)
    else $error("enable pin not inverted command");
  a_clear_held_low: assert property ($rose(faultActive) && $past(driverEnabled) |-> !enablePin [*8])
    else $error("clear pulse too short");
  a_clear_issued: assert property ($rose(faultActive) && $past(driverEnabled) |-> ##[9:30] enablePin)
    else $error("no clear issued");
endmodule

// ===== test/gdc_controller_bench.sv
// Bench for the gate driver controller against the driver model
`timescale 1ns/1ps
`define CHK(a, b) begin nTests++; if ((a) !== (b)) begin errTotal++; $display("Error t=%0t got %h exp %h", $time, a, b); end end
`define WAITFOR(c) begin n = 0; while (!(c) && n < 200) begin @(negedge sys_clk); n++; end if (n == 200) begin errTotal++; printVerdict; end end
module gdc_controller_bench;
  logic sys_clk = 0, rst = 1, pwmCmd = 0, useInverting = 0, autoReset = 0, enableReq = 0;
  logic ocTrip = 0, supplyLow = 0;
  wire pwmNonInv, pwmInv, enablePin, faultFlagPin, readyPin, driverEnabled, faultActive;
  wire supplyGood, clearBusy, gate;
  int errTotal = 0, nTests = 0, n;
  initial forever #4 sys_clk = ~sys_clk;
  gdc_controller #(.MUTE_CYCLES(10), .CLEAR_CYCLES(5)) i_dut (.sys_clk(sys_clk), .rst(rst),
    .pwmCmd(pwmCmd), .useInverting(useInverting), .autoReset(autoReset), .enableReq(enableReq),
    .clearReq(1'b0), .pwmNonInv(pwmNonInv), .pwmInv(pwmInv), .enablePin(enablePin),
    .faultFlagPin(faultFlagPin), .readyPin(readyPin), .driverEnabled(driverEnabled),
    .faultActive(faultActive), .supplyGood(supplyGood), .clearBusy(clearBusy));
  gdc_driver_model i_drv (.sys_clk(sys_clk), .nonInv(pwmNonInv), .inv(pwmInv), .enPin(enablePin),
    .ocTrip(ocTrip), .supplyLow(supplyLow), .faultFlagPin(faultFlagPin), .readyPin(readyPin),
    .gate(gate));
  task printVerdict;
    $display("Checks %0d mismatches %0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task runEnable;
    enableReq = 1;
    pwmCmd = 1;
    `WAITFOR(driverEnabled)
    repeat (2) @(negedge sys_clk);
    `CHK(pwmInv, 1'b0)
    `CHK(enablePin, 1'b1)
    `CHK(gate, 1'b1)
  endtask
  task runFault;
    ocTrip = 1;
    @(negedge sys_clk);
    ocTrip = 0;
    `WAITFOR(faultActive)
    `CHK(enablePin, 1'b0)
    `CHK(clearBusy, 1'b1)
    `WAITFOR(enablePin)
    `WAITFOR(driverEnabled && !faultActive)
    `CHK(gate, 1'b1)
  endtask
  task runAuto(input logic inv);
    enableReq = 0;
    `WAITFOR(!driverEnabled)
    useInverting = inv;
    autoReset = 1;
    enableReq = 1;
    `WAITFOR(driverEnabled)
    repeat (4) begin
      pwmCmd = ~pwmCmd;
      repeat (2) @(negedge sys_clk);
      `CHK(inv ? pwmInv : pwmNonInv, inv ? ~pwmCmd : pwmCmd)
      `CHK(enablePin, pwmCmd)
    end
  endtask
  task runSupply;
    supplyLow = 1;
    `WAITFOR(!supplyGood)
    `CHK(gate, 1'b0)
    supplyLow = 0;
    `WAITFOR(supplyGood)
    `CHK(supplyGood, 1'b1)
  endtask
  initial begin
    repeat (2) @(negedge sys_clk);
    rst = 0;
    runEnable;
    runFault;
    runAuto(1'b1);
    runAuto(1'b0);
    runSupply;
    printVerdict;
  end
endmodule
bind gdc_controller gdc_controller_checker i_chk (.sys_clk(sys_clk), .rst(rst),
  .useInverting(useInverting), .autoReset(autoReset), .pwmNonInv(pwmNonInv), .pwmInv(pwmInv),
  .enablePin(enablePin), .driverEnabled(driverEnabled), .faultActive(faultActive),
  .clearBusy(clearBusy));
